// *** sstp_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module sstp_port import sstp_pkg::*; #(
  parameter int HALF_DIV = SSTP_HALF_DEF
) (
  // System
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  input wire sstp_cfg_t cfg,
  input wire logic [SSTP_NCS-1:0] cs_enable_reg,
  input wire logic [2:0] gp_latch_reg,
  input wire logic [2:0] gp_direction_reg,
  // Data
  input wire logic [15:0] transmit_buffer,
  input wire logic tb_write,
  output logic [15:0] receive_buffer,
  output logic rx_done_flag,
  output logic tx_request_flag,
  output logic transfer_busy_flag,
  // Link
  input wire logic link_clk,
  input wire logic master_tx_slave_rx_line_in,
  input wire logic master_rx_slave_tx_line_in,
  output logic sclk_out,
  output logic sclk_oe_n,
  output logic master_tx_slave_rx_line_out,
  output logic master_tx_slave_rx_line_oe_n,
  output logic master_rx_slave_tx_line_out,
  output logic master_rx_slave_tx_line_oe_n,
  output logic [SSTP_NCS-1:0] chip_select_n
);
  localparam int HCW = $clog2(HALF_DIV + 1);

  if (HALF_DIV < 1 || HALF_DIV > 65536) begin : g_chk
    $error("HALF_DIV out of range");
  end

  // ----------------------------------------------------------------
  // Bit ordering
  // ----------------------------------------------------------------
  // First bit to go out lands in bit 15
  function automatic logic [15:0] ord(input logic [15:0] w, input logic [4:0] n, input logic msb);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < SSTP_WMAX; i++) begin
      if (i < int'(n)) begin
        r[15-i] = msb ? w[int'(n)-1-i] : w[i];
      end
    end
    return r;
  endfunction

  // First received bit sits at n-1; result is right aligned
  function automatic logic [15:0] unord(input logic [15:0] s, input logic [4:0] n, input logic msb);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < SSTP_WMAX; i++) begin
      if (i < int'(n)) begin
        r[i] = msb ? s[i] : s[int'(n)-1-i];
      end
    end
    return r;
  endfunction

  logic m_en;
  logic s_en;
  logic last;
  logic tick;
  logic m_start;
  logic m_mid;
  logic m_end;
  logic m_cont;
  logic s_take;
  logic s_start;
  logic s_done;
  logic alt_clk;
  logic alt_master_tx_slave_rx_line;
  logic alt_master_rx_slave_tx_line;
  logic slv_bit;
  logic [2:0] sync_in;
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;
  logic [2:0] acc_q;
  logic [2:0] agree;
  logic [2:0] acc_d;
  logic [2:0] chg;
  sstp_st_t st_q;
  logic [HCW-1:0] hc_q;
  logic ph_q;
  logic act_q;
  logic cs_q;
  logic [4:0] bit_q;
  logic [15:0] msh_q;
  logic mdo_q;
  logic [15:0] tb_q;
  logic tb_full_q;
  logic [15:0] rb_q;
  logic rx_q;
  logic tx_q;
  logic busy_q;
  logic [15:0] slv_tx_q;
  logic slv_full_q;
  logic lsrc_q;
  logic lclk;
  logic [4:0] lcnt_q;
  logic [15:0] lsh_q;
  logic [15:0] lcur;
  logic [15:0] lrx_q;
  logic ldone_t_q;
  logic lstart_t_q;
  logic lout_q;

  assign m_en = cfg.block_enable_bit & cfg.master_select_bit;
  assign s_en = cfg.block_enable_bit & ~cfg.master_select_bit;
  assign last = (bit_q == cfg.width - 5'd1);
  assign tick = (hc_q == HCW'(HALF_DIV - 1));

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // A change counts only once stages two and three agree
  assign sync_in = {lstart_t_q, ldone_t_q, master_rx_slave_tx_line_in};
  assign agree = ~(s2_q ^ s3_q);
  assign chg = agree & (s3_q ^ acc_q);
  // Next accepted level, so the master samples a bit that settled this very edge
  assign acc_d = (acc_q & ~agree) | (s3_q & agree);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      acc_q <= '0;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      acc_q <= acc_d;
    end
  end

  assign s_start = s_en & chg[2];
  assign s_done = s_en & chg[1];

  // ----------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------
  assign m_start = m_en & (st_q == ST_IDLE) & tb_full_q;
  assign m_mid = m_en & (st_q == ST_BIT) & tick & ~ph_q;
  assign m_end = m_en & (st_q == ST_BIT) & tick & ph_q & last;
  assign m_cont = m_end & tb_full_q;

  always_ff @(posedge clk) begin
    if (sys_rst || !m_en) begin
      st_q <= ST_IDLE;
      hc_q <= '0;
      ph_q <= 1'b0;
      act_q <= 1'b0;
      cs_q <= 1'b0;
      bit_q <= '0;
    end else begin
      hc_q <= (st_q == ST_IDLE || tick) ? '0 : hc_q + 1'b1;
      unique case (st_q)
        ST_IDLE: begin
          if (tb_full_q) begin
            st_q <= ST_LEAD;
            cs_q <= 1'b1;
          end
        end
        ST_LEAD: begin
          if (tick) begin
            st_q <= ST_BIT;
            act_q <= cfg.clock_phase_bit;
            ph_q <= 1'b0;
            bit_q <= '0;
          end
        end
        ST_BIT: begin
          if (tick && !ph_q) begin
            act_q <= ~cfg.clock_phase_bit;
            ph_q <= 1'b1;
          end else if (tick) begin
            ph_q <= 1'b0;
            if (!last) begin
              bit_q <= bit_q + 5'd1;
              act_q <= cfg.clock_phase_bit;
            end else if (tb_full_q) begin
              bit_q <= '0;
              act_q <= cfg.clock_phase_bit;
            end else begin
              act_q <= 1'b0;
              st_q <= ST_TAIL;
            end
          end
        end
        ST_TAIL: begin
          if (tick) begin
            st_q <= ST_IDLE;
            cs_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Master shift register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msh_q <= '0;
      mdo_q <= SSTP_DO_RST;
    end else begin
      if (m_start || m_cont) begin
        msh_q <= ord(tb_q, cfg.width, cfg.msb_first);
      end else if (m_mid) begin
        msh_q <= {msh_q[14:0], acc_d[0]};
      end
      if (m_en && st_q == ST_LEAD && tick) begin
        mdo_q <= msh_q[15];
      end else if (m_en && st_q == ST_BIT && tick && ph_q && !last) begin
        mdo_q <= msh_q[15];
      end else if (m_cont) begin
        mdo_q <= tb_q[int'(cfg.msb_first ? cfg.width - 5'd1 : 5'd0)];
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffers and flags
  // ----------------------------------------------------------------
  assign s_take = s_en & tb_full_q & ~slv_full_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tb_q <= '0;
      tb_full_q <= 1'b0;
    end else if (tb_write) begin
      tb_q <= transmit_buffer;
      tb_full_q <= 1'b1;
    end else if (m_start || m_cont || s_take) begin
      tb_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rb_q <= '0;
      rx_q <= 1'b0;
      tx_q <= 1'b0;
    end else begin
      rx_q <= m_end | s_done;
      tx_q <= m_start | m_cont | s_take;
      if (m_end) begin
        rb_q <= unord(msh_q, cfg.width, cfg.msb_first);
      end else if (s_done) begin
        rb_q <= lrx_q;
      end
    end
  end

  // Start wins over end when both land together
  always_ff @(posedge clk) begin
    if (sys_rst || !cfg.block_enable_bit) begin
      busy_q <= 1'b0;
    end else if (m_start || s_start) begin
      busy_q <= 1'b1;
    end else if ((m_end && !tb_full_q) || (s_done && !slv_full_q && !tb_full_q)) begin
      busy_q <= 1'b0;
    end
  end

  // Unreloaded slave resends what it last received
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slv_tx_q <= '0;
      slv_full_q <= 1'b0;
    end else begin
      if (s_take) begin
        slv_tx_q <= ord(tb_q, cfg.width, cfg.msb_first);
      end else if (s_done && !slv_full_q) begin
        slv_tx_q <= ord(lrx_q, cfg.width, cfg.msb_first);
      end
      if (s_take) begin
        slv_full_q <= 1'b1;
      end else if (s_start || !s_en) begin
        slv_full_q <= 1'b0;
      end
    end
  end

  assign receive_buffer = rb_q;
  assign rx_done_flag = rx_q;
  assign tx_request_flag = tx_q;
  assign transfer_busy_flag = busy_q;

  // ----------------------------------------------------------------
  // Slave link domain
  // ----------------------------------------------------------------
  // Latch edge becomes the rising edge of lclk; settings are static while enabled
  assign lclk = link_clk ^ (cfg.clock_idle_polarity ^ cfg.clock_phase_bit);
  assign lcur = (lcnt_q == 5'd0) ? slv_tx_q : lsh_q;

  // Quasi-static level: the link clock only runs in frames, so a synchroniser would eat the first edges
  always_ff @(posedge clk) begin
    lsrc_q <= sys_rst | ~s_en;
  end

  // Toggles clear while off; the system side ignores them then and settles before re-enable
  always_ff @(posedge lclk) begin
    if (lsrc_q) begin
      ldone_t_q <= 1'b0;
      lstart_t_q <= 1'b0;
    end else begin
      if (lcnt_q == 5'd0) begin
        lstart_t_q <= ~lstart_t_q;
      end
      if (lcnt_q == cfg.width - 5'd1) begin
        ldone_t_q <= ~ldone_t_q;
      end
    end
  end

  always_ff @(posedge lclk) begin
    if (lsrc_q) begin
      lcnt_q <= '0;
      lsh_q <= '0;
      lrx_q <= '0;
    end else begin
      lsh_q <= {lcur[14:0], master_tx_slave_rx_line_in};
      if (lcnt_q == cfg.width - 5'd1) begin
        lcnt_q <= '0;
        lrx_q <= unord({lcur[14:0], master_tx_slave_rx_line_in}, cfg.width, cfg.msb_first);
      end else begin
        lcnt_q <= lcnt_q + 5'd1;
      end
    end
  end

  always_ff @(negedge lclk) begin
    if (lsrc_q) begin
      lout_q <= SSTP_DO_RST;
    end else begin
      lout_q <= (lcnt_q == 5'd0) ? slv_tx_q[15] : lsh_q[15];
    end
  end

  // Between frames the pending word's first bit is shown at once
  assign slv_bit = (lcnt_q == 5'd0) ? slv_tx_q[15] : lout_q;

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign alt_clk = m_en ? (cfg.clock_idle_polarity ^ act_q) : SSTP_ALT_OFF;
  assign alt_master_tx_slave_rx_line = m_en ? mdo_q : SSTP_ALT_OFF;
  assign alt_master_rx_slave_tx_line = s_en ? slv_bit : SSTP_ALT_OFF;
  assign sclk_out = alt_clk & gp_latch_reg[SSTP_GP_CLK];
  assign master_tx_slave_rx_line_out = alt_master_tx_slave_rx_line & gp_latch_reg[SSTP_GP_MASTER_TX_SLAVE_RX_LINE];
  assign master_rx_slave_tx_line_out = alt_master_rx_slave_tx_line & gp_latch_reg[SSTP_GP_MASTER_RX_SLAVE_TX_LINE];
  assign sclk_oe_n = ~gp_direction_reg[SSTP_GP_CLK];
  assign master_tx_slave_rx_line_oe_n = ~gp_direction_reg[SSTP_GP_MASTER_TX_SLAVE_RX_LINE];
  assign master_rx_slave_tx_line_oe_n = ~gp_direction_reg[SSTP_GP_MASTER_RX_SLAVE_TX_LINE];

  for (genvar g = 0; g < SSTP_NCS; g++) begin : g_cs
    assign chip_select_n[g] = ~(cs_q & ~cs_enable_reg[g]);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  clk_slave_a: assert property (!m_en |-> sclk_out == gp_latch_reg[SSTP_GP_CLK])
    else $error("clock driven while not master");
  idle_level_a: assert property (m_en && st_q != ST_BIT |-> alt_clk == cfg.clock_idle_polarity)
    else $error("master clock left idle level");
  first_bit_a: assert property (m_en && st_q == ST_LEAD && tick |=> mdo_q == $past(msh_q[15]))
    else $error("first bit not driven at tick");
  exchange_a: assert property (m_mid |=> msh_q[0] == $past(acc_d[0]))
    else $error("input bit not latched");
  rx_done_a: assert property (m_end |=> rx_done_flag && receive_buffer == $past(unord(msh_q, cfg.width, cfg.msb_first)))
    else $error("receive word not delivered");
  cs_lead_a: assert property (m_start |=> cs_q && st_q == ST_LEAD && mdo_q == $past(mdo_q))
    else $error("select did not lead data");
  cs_idle_a: assert property (st_q == ST_IDLE |-> chip_select_n == '1)
    else $error("select active while idle");
  alt_off_a: assert property (!cfg.block_enable_bit |-> master_tx_slave_rx_line_out == gp_latch_reg[SSTP_GP_MASTER_TX_SLAVE_RX_LINE]
    && master_rx_slave_tx_line_out == gp_latch_reg[SSTP_GP_MASTER_RX_SLAVE_TX_LINE])
    else $error("alternate output low while disabled");
  tx_req_a: assert property ((m_start || s_take) && !tb_write |=> tx_request_flag && !tb_full_q)
    else $error("transmit request missing");
  cont_a: assert property (m_cont |=> st_q == ST_BIT && cs_q && bit_q == 5'd0 ##1 cs_q)
    else $error("continuous frame had a gap");
  busy_end_a: assert property (m_end && !tb_full_q |=> !transfer_busy_flag && rx_done_flag)
    else $error("busy not cleared with receive");

  cont_c: cover property (m_cont);
  tail_c: cover property (st_q == ST_TAIL ##1 st_q == ST_TAIL [*1] ##[1:64] st_q == ST_IDLE);
  slave_c: cover property (s_take ##[1:1000] s_done);
  start_c: cover property (m_start ##[1:300] m_end);
endmodule
`default_nettype wire

// *** sstp_pkg.sv ***
`default_nettype none
package sstp_pkg;
  // Notes on behaviour
  // - One device on the link is master with master_select_bit high; all others are slaves.
  // - Only the master drives the shift clock; a slave takes it as input.
  // - Enabled master idles clock at set level; data holds fixed, then last bit sent.
  // - Master copies transmit_buffer into empty shift register; first bit at next tick.
  // - Data shifts out on one clock edge and is latched in on the other.
  // - After width clock pulses the shift register goes to receive_buffer; rx_done_flag pulses.
  // - A slave shows its first bit as soon as the word enters its shift register.
  // - Every transfer sends and receives together, meaningful or not.
  // - Disabled, alternate outputs sit high and are ANDed with the port latches.
  // - Four active-low chip selects assert at transfer start and release after.
  // - Chip select leads first bit by half a bit, trails last bit by half.
  // - A zero cs_select_bit in cs_enable_reg makes that select assert.
  // - Half duplex: a sender samples its own data back from the shared line.
  // - tx_request_flag pulses when transmit_buffer has emptied into the shift register.
  // - A word pending at frame end starts the next frame with no gap.
  // - Clock on general bit 15, slave transmit data on 13, master transmit on 14.
  // - Hardware routes alternate lines per mode; software sets pin directions.
  // - Busy sets at transfer start, clears with receive when nothing is pending.
  // - Polarity sets clock idle level; phase picks leading or trailing shift edge.
  localparam int SSTP_WMAX = 16;
  localparam int SSTP_NCS = 4;
  localparam int SSTP_HALF_DEF = 4;
  localparam int SSTP_GP_CLK = 2;
  localparam int SSTP_GP_MASTER_TX_SLAVE_RX_LINE = 1;
  localparam int SSTP_GP_MASTER_RX_SLAVE_TX_LINE = 0;
  localparam logic SSTP_DO_RST = 1'b1;
  localparam logic SSTP_ALT_OFF = 1'b1;
  typedef struct packed {
    logic block_enable_bit;
    logic master_select_bit;
    logic msb_first;
    logic clock_idle_polarity;
    logic clock_phase_bit;
    logic [4:0] width;
  } sstp_cfg_t;
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_BIT, ST_TAIL} sstp_st_t;
endpackage
`default_nettype wire

// *** sstp_port_end.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** sstp_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module sstp_far_end import sstp_pkg::*; (
  // Control
  input wire logic dut_master,
  input wire logic [4:0] width,
  input wire logic [15:0] word,
  input wire logic load,
  input wire logic go,
  // Pins
  input wire logic sel_n,
  input wire logic sclk_w,
  input wire logic din,
  output logic clk_drv,
  output logic dout,
  output logic [15:0] got
);
  logic [15:0] sh;
  logic smp;
  logic act;
  initial begin
    clk_drv = 1'b0;
    sh = 16'hFFFF;
    smp = 1'b1;
    act = 1'b0;
  end
  always @(posedge load) sh = word;
  // Clock only runs inside a frame; whole words only
  always @(posedge go) begin
    act = 1'b1;
    repeat (width) begin
      #40 clk_drv = 1'b1;
      #40 clk_drv = 1'b0;
    end
    #40 act = 1'b0;
  end
  always @(posedge sclk_w) smp = din;
  always @(negedge sclk_w) sh = {sh[14:0], smp};
  assign got = sh;
  // Released line shows the inverse so a stale level cannot pass
  assign dout = (dut_master ? !sel_n : act) ? sh[width-1] : ~sh[width-1];
endmodule
`default_nettype wire

// *** sync_serial_transfer_port_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module sync_serial_transfer_port_bench import sstp_pkg::*;;
  localparam int H = 4;
  logic clk, sys_rst, tb_write, hd, p_load, p_go, p_clk, p_dat;
  sstp_cfg_t cfg;
  logic [3:0] cs_enable_reg, chip_select_n;
  logic [2:0] gp_latch_reg, gp_direction_reg;
  logic [15:0] transmit_buffer, receive_buffer, p_word, p_got;
  logic rx_done_flag, tx_request_flag, transfer_busy_flag;
  logic sclk_out, sclk_oe_n, master_tx_slave_rx_line_out, master_tx_slave_rx_line_oe_n, master_rx_slave_tx_line_out, master_rx_slave_tx_line_oe_n;
  wire sclk_w, master_tx_slave_rx_line_w, master_rx_slave_tx_line_w;
  int bad_count, tests_run, cyc;
  // --------------------------------
  // Wire resolution
  // --------------------------------
  assign sclk_w = sclk_oe_n ? p_clk : sclk_out;
  assign master_tx_slave_rx_line_w = master_tx_slave_rx_line_oe_n ? p_dat : master_tx_slave_rx_line_out;
  assign master_rx_slave_tx_line_w = hd ? master_tx_slave_rx_line_w : (master_rx_slave_tx_line_oe_n ? p_dat : master_rx_slave_tx_line_out);
  sstp_port #(.HALF_DIV(H)) dut (.clk(clk), .sys_rst(sys_rst), .cfg(cfg), .cs_enable_reg(cs_enable_reg),
    .gp_latch_reg(gp_latch_reg), .gp_direction_reg(gp_direction_reg), .transmit_buffer(transmit_buffer),
    .tb_write(tb_write), .receive_buffer(receive_buffer), .rx_done_flag(rx_done_flag),
    .tx_request_flag(tx_request_flag), .transfer_busy_flag(transfer_busy_flag), .link_clk(sclk_w),
    .master_tx_slave_rx_line_in(master_tx_slave_rx_line_w), .master_rx_slave_tx_line_in(master_rx_slave_tx_line_w), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .master_tx_slave_rx_line_out(master_tx_slave_rx_line_out),
    .master_tx_slave_rx_line_oe_n(master_tx_slave_rx_line_oe_n), .master_rx_slave_tx_line_out(master_rx_slave_tx_line_out), .master_rx_slave_tx_line_oe_n(master_rx_slave_tx_line_oe_n), .chip_select_n(chip_select_n));
  sstp_far_end far (.dut_master(cfg.master_select_bit), .width(cfg.width), .word(p_word), .load(p_load),
    .go(p_go), .sel_n(chip_select_n[0]), .sclk_w(sclk_w), .din(cfg.master_select_bit ? master_tx_slave_rx_line_w : master_rx_slave_tx_line_w),
    .clk_drv(p_clk), .dout(p_dat), .got(p_got));
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic write_word(input logic [15:0] w);
    @(negedge clk);
    transmit_buffer = w;
    tb_write = 1'b1;
    @(negedge clk);
    tb_write = 1'b0;
  endtask
  task automatic far_load(input logic [15:0] w);
    p_word = w;
    p_load = 1'b1;
    #1 p_load = 1'b0;
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    while (rx_done_flag !== 1'b1 && k < 600) begin
      @(negedge clk);
      k++;
    end
    check(16'(k < 600), 16'h0001);
  endtask
  // Disable first: width may only change while off
  task automatic setup(input logic ms, input logic msb, input logic [4:0] w, input logic [2:0] dir);
    @(negedge clk);
    cfg = '{1'b0, ms, msb, 1'b0, 1'b0, w};
    gp_latch_reg = 3'b011;
    gp_direction_reg = dir;
    tick(1);
    cfg.block_enable_bit = 1'b1;
    tick(1);
    check(sclk_out, 1'b0);
    gp_latch_reg = 3'b111;
    tick(1);
  endtask
  // --------------------------------
  // Clock, timeout, sequence
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      $display("unexpected at %0t: run too long", $time);
      summarize();
    end
  end
  initial begin
    sys_rst = 1'b1; tb_write = 1'b0; hd = 1'b0; p_load = 1'b0; p_go = 1'b0; p_word = '0;
    transmit_buffer = '0; cfg = '0; cs_enable_reg = 4'hF; gp_latch_reg = 3'b101; gp_direction_reg = 3'b110;
    bad_count = 0; tests_run = 0; cyc = 0;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check(chip_select_n, 4'hF);
    check({rx_done_flag, tx_request_flag, transfer_busy_flag}, 3'b000);
    check(receive_buffer, 16'h0000);
    check({sclk_out, master_tx_slave_rx_line_out, master_rx_slave_tx_line_out}, 3'b101);
    check({sclk_oe_n, master_tx_slave_rx_line_oe_n, master_rx_slave_tx_line_oe_n}, 3'b001);
    // Master single frame
    cs_enable_reg = 4'b1010;
    setup(1'b1, 1'b1, 5'd8, 3'b110);
    check({sclk_out, master_tx_slave_rx_line_out}, 2'b01);
    far_load(16'h003C);
    write_word(16'h005A);
    check(tx_request_flag, 1'b0);
    tick(1);
    check({tx_request_flag, transfer_busy_flag}, 2'b11);
    check(chip_select_n, 4'b1010);
    tick(H - 1);
    check(master_tx_slave_rx_line_out, 1'b1);
    tick(1);
    check(master_tx_slave_rx_line_out, 1'b0);
    wait_done();
    check(receive_buffer[7:0], 8'h3C);
    check({chip_select_n, transfer_busy_flag}, 5'b10100);
    tick(H + 2);
    check(chip_select_n, 4'hF);
    check(p_got[7:0], 8'h5A);
    check({sclk_out, master_tx_slave_rx_line_out}, 2'b00);
    // Back-to-back frames
    far_load(16'h00C3);
    write_word(16'h0081);
    tick(2);
    write_word(16'h007E);
    wait_done();
    check(receive_buffer[7:0], 8'hC3);
    check({chip_select_n, transfer_busy_flag}, 5'b10101);
    tick(1);
    wait_done();
    check(receive_buffer[7:0], 8'h81);
    check(p_got, 16'h817E);
    // Half duplex, full width, lsb first
    hd = 1'b1;
    setup(1'b1, 1'b0, 5'd16, 3'b110);
    write_word(16'hB00D);
    wait_done();
    check(receive_buffer, 16'hB00D);
    // Slave frame
    hd = 1'b0;
    setup(1'b0, 1'b1, 5'd8, 3'b001);
    write_word(16'h0043);
    tick(1);
    check(tx_request_flag, 1'b1);
    check({sclk_oe_n, master_rx_slave_tx_line_oe_n, master_rx_slave_tx_line_out}, 3'b100);
    far_load(16'h0096);
    p_go = 1'b1;
    #1 p_go = 1'b0;
    wait_done();
    check(receive_buffer[7:0], 8'h96);
    check(p_got[7:0], 8'h43);
    summarize();
  end
endmodule
`default_nettype wire
